// ### logic/compare_sync_source_select.sv
// Purpose: Output compare channel with trigger/sync source selection on APB
// Assumes: pclk 100 MHz, presetn async active low, source pins asynchronous
// Notes:   Zero-wait APB slave, unmapped addresses read zero with no error
// Summary of operation
// - Five-bit source selector sits in bits 4-0 of trigger control register
// - Code 11111 restarts the timer on the channel's own secondary match
// - Codes 11110 and 11101 select interrupt pin b and pin a
// - Code 10000 selects the capture unit interrupt event
// - Codes 01101, 01100, 01011 select timers c, b, a; 01100 default
// - Code 00101 selects the capture event itself
// - Code 00000 means no source; the timer runs freely
// - With status mode set, secondary match clears trigger status; else software
// - Compare mode 000 disables the channel regardless of source
//
// The implementer's own choices: the APB interface to the registers and the register offsets.
`default_nettype none
module compare_sync_source_select #(
  parameter int TMR_W = 16
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        general_timer_a,
  input  wire logic        general_timer_b,
  input  wire logic        general_timer_c,
  input  wire logic        capture_unit_event,
  input  wire logic        capture_unit_irq,
  input  wire logic        analog_comparator_a,
  input  wire logic        analog_comparator_b,
  input  wire logic        external_irq_pin_a,
  input  wire logic        external_irq_pin_b,
  output logic             compare_out,
  output logic             compare_out_oe_n
);
  logic [15:0]      ctrl1_q;
  logic [15:0]      ctrl2_q;
  logic [TMR_W-1:0] timer_q;
  logic [TMR_W-1:0] primary_q;
  logic [TMR_W-1:0] secondary_q;
  logic             out_q;
  logic [8:0]       meta_q;
  logic [8:0]       sync_q;
  logic             irqb_prev_q;
  logic             wr;
  logic             wr_ctrl1;
  logic             wr_ctrl2;
  logic             wr_timer;
  logic             wr_primary;
  logic             wr_secondary;
  logic             sec_match;
  logic             pri_match;
  logic             ev;
  logic             ev_all;
  logic [4:0]       sel;
  logic [2:0]       mode;
  logic             trig_mode;
  logic             running;
  source_sync_if    ssi ();

  // Register writes decode in one place so every block sees the same strobe
  function automatic logic wr_hit(input logic       strobe,
                                  input logic [7:0] addr,
                                  input logic [7:0] offset);
    return strobe && (addr == offset);
  endfunction

  assign wr      = psel & penable & pwrite;
  assign wr_ctrl1     = wr_hit(wr, paddr, compare_sync_pkg::CTRL1_OFFSET);
  assign wr_ctrl2     = wr_hit(wr, paddr, compare_sync_pkg::CTRL2_OFFSET);
  assign wr_timer     = wr_hit(wr, paddr, compare_sync_pkg::TIMER_OFFSET);
  assign wr_primary   = wr_hit(wr, paddr, compare_sync_pkg::PRIMARY_OFFSET);
  assign wr_secondary = wr_hit(wr, paddr, compare_sync_pkg::SECONDARY_OFFSET);
  assign pready  = 1'b1;
  assign pslverr = 1'b0;
  assign sel     = ctrl2_q[compare_sync_pkg::SEL_LSB +: compare_sync_pkg::SEL_W];
  assign mode    = ctrl1_q[compare_sync_pkg::MODE_LSB +: compare_sync_pkg::MODE_W];
  assign trig_mode = ctrl2_q[compare_sync_pkg::TRIGSEL_BIT];
  assign sec_match = (timer_q == secondary_q);
  assign pri_match = (timer_q == primary_q);

  // Two flops on every external source before any logic looks at it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= 9'h000;
      sync_q <= 9'h000;
    end else begin
      meta_q <= {external_irq_pin_b, external_irq_pin_a, analog_comparator_b,
                 analog_comparator_a, capture_unit_irq, capture_unit_event,
                 general_timer_c, general_timer_b, general_timer_a};
      sync_q <= meta_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irqb_prev_q <= 1'b0;
    end else begin
      irqb_prev_q <= sync_q[8];
    end
  end

  assign ssi.sel       = sel;
  assign ssi.sources   = sync_q[7:0];
  assign ssi.own_match = sec_match;

  source_picker u_picker (
    .pclk    (pclk),
    .presetn (presetn),
    .bus     (ssi)
  );

  // Interrupt pin b handled here so the picker keeps an 8-bit source bus
  assign ev_all = (sel == compare_sync_pkg::SEL_IRQ_B) ? (sync_q[8] & ~irqb_prev_q)
                                                       : ssi.event_pulse;
  // Sync mode restarts the timer; no source (00000) means always running
  assign ev = ev_all & (sel != compare_sync_pkg::SEL_NONE);
  // Trigger mode: timer counts while the status flag is set, and in the cycle the trigger event arrives
  assign running = (mode != compare_sync_pkg::MODE_OFF) &
                   (~trig_mode | ctrl2_q[compare_sync_pkg::TRIGGER_STATUS_FLAG_BIT] | ev);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl1_q <= 16'h0000;
    end else if (wr_ctrl1) begin
      ctrl1_q <= pwdata[15:0] & compare_sync_pkg::CTRL1_WMASK;
    end
  end

  // Trigger status: hardware set wins over any clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl2_q <= compare_sync_pkg::CTRL2_RESET;
    end else begin
      if (wr_ctrl2) begin
        ctrl2_q <= pwdata[15:0] & compare_sync_pkg::CTRL2_WMASK;
      end else if (ctrl1_q[compare_sync_pkg::TRIGGER_STATUS_MODE_BIT] && sec_match) begin
        ctrl2_q[compare_sync_pkg::TRIGGER_STATUS_FLAG_BIT] <= 1'b0;
      end
      if (trig_mode && ev && mode != compare_sync_pkg::MODE_OFF) begin
        ctrl2_q[compare_sync_pkg::TRIGGER_STATUS_FLAG_BIT] <= 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      primary_q   <= '0;
      secondary_q <= '0;
    end else begin
      if (wr_primary) begin
        primary_q <= pwdata[TMR_W-1:0];
      end
      if (wr_secondary) begin
        secondary_q <= pwdata[TMR_W-1:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_q <= '0;
    end else if (wr_timer) begin
      timer_q <= pwdata[TMR_W-1:0];
    end else if (mode == compare_sync_pkg::MODE_OFF) begin
      timer_q <= '0;
    end else if (!trig_mode && ev) begin
      timer_q <= '0;
    end else if (running) begin
      timer_q <= timer_q + 1'b1;
    end
  end

  // Output waveform per compare mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_q <= 1'b0;
    end else if (wr_ctrl1) begin
      out_q <= (pwdata[2:0] == compare_sync_pkg::MODE_SS_LOW);
    end else if (running) begin
      case (mode)
        compare_sync_pkg::MODE_SS_HIGH: if (pri_match) out_q <= 1'b1;
        compare_sync_pkg::MODE_SS_LOW:  if (pri_match) out_q <= 1'b0;
        compare_sync_pkg::MODE_TOGGLE:  if (pri_match) out_q <= ~out_q;
        compare_sync_pkg::MODE_DBL_SINGLE: begin
          if (pri_match) out_q <= 1'b1;
          else if (sec_match) out_q <= 1'b0;
        end
        compare_sync_pkg::MODE_DBL_CONT: if (pri_match || sec_match) out_q <= ~out_q;
        compare_sync_pkg::MODE_EDGE_PWM: begin
          if (timer_q == '0) out_q <= 1'b1;
          else if (pri_match) out_q <= 1'b0;
        end
        compare_sync_pkg::MODE_CTR_PWM: begin
          if (pri_match) out_q <= 1'b1;
          else if (sec_match) out_q <= 1'b0;
        end
        default: out_q <= 1'b0;
      endcase
    end
  end

  assign compare_out      = out_q ^ ctrl2_q[compare_sync_pkg::INVERT_BIT];
  assign compare_out_oe_n = ctrl2_q[compare_sync_pkg::TRISTATE_BIT];

  // Captured in the setup cycle so the data stands through the whole access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        compare_sync_pkg::CTRL1_OFFSET:     prdata <= {16'h0000, ctrl1_q};
        compare_sync_pkg::CTRL2_OFFSET:     prdata <= {16'h0000, ctrl2_q};
        compare_sync_pkg::TIMER_OFFSET:     prdata <= 32'(timer_q);
        compare_sync_pkg::PRIMARY_OFFSET:   prdata <= 32'(primary_q);
        compare_sync_pkg::SECONDARY_OFFSET: prdata <= 32'(secondary_q);
        default:                            prdata <= 32'h0000_0000;
      endcase
    end
  end
endmodule : compare_sync_source_select
`default_nettype wire

// ### logic/compare_sync_pkg.sv
// Purpose: Constants shared by the compare source select block
// Assumes: APB with 32-bit data, 16-bit control registers in the low bits
// Notes:   Offsets are byte addresses
`default_nettype none
package compare_sync_pkg;
  localparam logic [7:0]  CTRL1_OFFSET    = 8'h00;
  localparam logic [7:0]  CTRL2_OFFSET    = 8'h04;
  localparam logic [7:0]  TIMER_OFFSET    = 8'h08;
  localparam logic [7:0]  PRIMARY_OFFSET  = 8'h0c;
  localparam logic [7:0]  SECONDARY_OFFSET = 8'h10;
  localparam int          SEL_LSB         = 0;
  localparam int          SEL_W           = 5;
  localparam int          TRISTATE_BIT    = 5;
  localparam int          TRIGGER_STATUS_FLAG_BIT    = 6;
  localparam int          TRIGSEL_BIT     = 7;
  localparam int          INVERT_BIT      = 12;
  localparam int          TRIGGER_STATUS_MODE_BIT    = 3;
  localparam int          MODE_LSB        = 0;
  localparam int          MODE_W          = 3;
  localparam logic [15:0] CTRL2_RESET     = 16'h000c;
  localparam logic [15:0] CTRL2_WMASK     = 16'h10ff;
  localparam logic [15:0] CTRL1_WMASK     = 16'h000f;
  localparam logic [4:0]  SEL_OWN_MATCH   = 5'h1f;
  localparam logic [4:0]  SEL_IRQ_B       = 5'h1e;
  localparam logic [4:0]  SEL_IRQ_A       = 5'h1d;
  localparam logic [4:0]  SEL_CMP_B       = 5'h19;
  localparam logic [4:0]  SEL_CMP_A       = 5'h18;
  localparam logic [4:0]  SEL_CAP_IRQ     = 5'h10;
  localparam logic [4:0]  SEL_TIMER_C     = 5'h0d;
  localparam logic [4:0]  SEL_TIMER_B     = 5'h0c;
  localparam logic [4:0]  SEL_TIMER_A     = 5'h0b;
  localparam logic [4:0]  SEL_CAP_EVENT   = 5'h05;
  localparam logic [4:0]  SEL_NONE        = 5'h00;
  localparam logic [2:0]  MODE_OFF        = 3'h0;
  localparam logic [2:0]  MODE_SS_HIGH    = 3'h1;
  localparam logic [2:0]  MODE_SS_LOW     = 3'h2;
  localparam logic [2:0]  MODE_TOGGLE     = 3'h3;
  localparam logic [2:0]  MODE_DBL_SINGLE = 3'h4;
  localparam logic [2:0]  MODE_DBL_CONT   = 3'h5;
  localparam logic [2:0]  MODE_EDGE_PWM   = 3'h6;
  localparam logic [2:0]  MODE_CTR_PWM    = 3'h7;
endpackage : compare_sync_pkg
`default_nettype wire

// ### logic/source_sync_if.sv
// Purpose: Carries the selected source event between top and selector
// Assumes: Single clock domain
// Notes:   Source inputs arrive already synchronised
`default_nettype none
interface source_sync_if;
  logic [4:0] sel;
  logic [7:0] sources;
  logic       own_match;
  logic       event_pulse;
  modport top (output sel, output sources, output own_match, input event_pulse);
  modport picker (input sel, input sources, input own_match, output event_pulse);
endinterface : source_sync_if
`default_nettype wire

// ### logic/source_picker.sv
// Purpose: Decodes the source selector and picks one rising source event
// Assumes: sources[] = timer a,b,c, capture event, capture irq, cmp a,b, irq a
// Notes:   Reserved codes pick nothing
`default_nettype none
module source_picker (
  input  wire logic   pclk,
  input  wire logic   presetn,
  source_sync_if.picker bus
);
  logic [7:0] prev_q;
  logic       level;

  // Sources are treated as levels; only their rising edge counts as an event
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_q <= 8'h00;
    end else begin
      prev_q <= bus.sources;
    end
  end

  always_comb begin
    level = 1'b0;
    case (bus.sel)
      compare_sync_pkg::SEL_TIMER_A:   level = bus.sources[0] & ~prev_q[0];
      compare_sync_pkg::SEL_TIMER_B:   level = bus.sources[1] & ~prev_q[1];
      compare_sync_pkg::SEL_TIMER_C:   level = bus.sources[2] & ~prev_q[2];
      compare_sync_pkg::SEL_CAP_EVENT: level = bus.sources[3] & ~prev_q[3];
      compare_sync_pkg::SEL_CAP_IRQ:   level = bus.sources[4] & ~prev_q[4];
      compare_sync_pkg::SEL_CMP_A:     level = bus.sources[5] & ~prev_q[5];
      compare_sync_pkg::SEL_CMP_B:     level = bus.sources[6] & ~prev_q[6];
      compare_sync_pkg::SEL_IRQ_A:     level = bus.sources[7] & ~prev_q[7];
      compare_sync_pkg::SEL_IRQ_B:     level = 1'b0; // Pin b is edge-detected in the top module
      compare_sync_pkg::SEL_OWN_MATCH: level = bus.own_match;
      compare_sync_pkg::SEL_NONE:      level = 1'b0;
      default:                         level = 1'b0;
    endcase
  end

  assign bus.event_pulse = level;
endmodule : source_picker
`default_nettype wire

// ### verification/compare_sync_chk.sv
// Purpose: Port-level checks for the compare source select block
// Assumes: Zero-wait APB, shadow copies of the control registers
// Notes:   Status bit is hardware set, so readback ignores it
`default_nettype none
module compare_sync_chk #(
  parameter int TMR_W = 16
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        compare_out,
  input wire logic        compare_out_oe_n
);
  logic [3:0]  c1_q;
  logic [15:0] c2_q;
  logic        wr;
  logic        rd;
  assign wr = psel && penable && pwrite && pready;
  assign rd = psel && penable && !pwrite;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      c1_q <= 4'h0;
      c2_q <= compare_sync_pkg::CTRL2_RESET;
    end else if (wr && paddr == compare_sync_pkg::CTRL1_OFFSET) begin
      c1_q <= pwdata[3:0];
    end else if (wr && paddr == compare_sync_pkg::CTRL2_OFFSET) begin
      c2_q <= pwdata[15:0] & compare_sync_pkg::CTRL2_WMASK;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_no_error: assert property (psel && penable |-> pready && !pslverr)
    else $error("slave stalled or flagged an error");
  a_unmapped_zero: assert property (rd && paddr > 8'h10 |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  a_ctrl2_readback: assert property (rd && paddr == 8'h04 |->
    (prdata & 32'h0000ffbf) == {16'h0, c2_q & 16'hffbf}) else $error("ctrl2 readback wrong");
  a_ctrl1_readback: assert property (rd && paddr == 8'h00 |-> prdata == {28'h0, c1_q})
    else $error("ctrl1 readback wrong");
  a_tristate_pin: assert property (compare_out_oe_n == c2_q[5])
    else $error("pin enable does not follow tristate bit");
  a_invert_pin: assert property (c1_q[2:0] == 3'h0 && $stable(c1_q) && $changed(c2_q[12])
    |-> compare_out != $past(compare_out)) else $error("invert did not flip the pin");
  a_off_freeze: assert property (c1_q[2:0] == 3'h0 && $stable(c1_q) && $stable(c2_q[12])
    |-> $stable(compare_out)) else $error("disabled channel changed its pin");
  a_timer_idle: assert property (rd && paddr == 8'h08 && c1_q[2:0] == 3'h0
    && $past(c1_q[2:0], 2) == 3'h0 |-> prdata[TMR_W-1:0] == '0) else $error("timer ran while off");
endmodule // compare_sync_chk
bind compare_sync_source_select compare_sync_chk #(.TMR_W(TMR_W)) chk_u (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .compare_out(compare_out), .compare_out_oe_n(compare_out_oe_n));
`default_nettype wire

// ### verification/source_partner.sv
// Purpose: Model of the on-chip event sources beside the channel
// Assumes: Bit order timer a,b,c, capture event, capture irq, cmp a,b, irq a,b
// Notes:   Index beyond 8 raises nothing
`default_nettype none
module source_partner (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       fire,
  input  wire logic [3:0] idx,
  output var  logic [8:0] src
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] hold_q;
  // Held several cycles so the two-flop synchroniser cannot miss it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src    <= 9'h000;
      hold_q <= 2'h0;
    end else if (fire) begin
      src    <= 9'h001 << idx;
      hold_q <= 2'h3;
    end else if (hold_q != 2'h0) begin
      hold_q <= hold_q - 2'h1;
    end else begin
      src <= 9'h000;
    end
  end
endmodule // source_partner
`default_nettype wire

// ### verification/testbench.sv
// Purpose: Self-checking bench for the compare source select block
// Assumes: Zero-wait APB slave, sources from source_partner
// Notes:   Timer bounds are loose because sync latency is a few cycles
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] C1 = compare_sync_pkg::CTRL1_OFFSET;
  localparam logic [7:0] C2 = compare_sync_pkg::CTRL2_OFFSET;
  localparam logic [7:0] TM = compare_sync_pkg::TIMER_OFFSET;
  localparam logic [7:0] SC = compare_sync_pkg::SECONDARY_OFFSET;
  logic        pclk, presetn, psel, penable, pwrite, fire, co, oen, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, r;
  logic [8:0]  src;
  logic [3:0]  idx;
  int          bad_count, checks_done, cyc;
  compare_sync_source_select dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .general_timer_a(src[0]), .general_timer_b(src[1]),
    .general_timer_c(src[2]), .capture_unit_event(src[3]), .capture_unit_irq(src[4]),
    .analog_comparator_a(src[5]), .analog_comparator_b(src[6]), .external_irq_pin_a(src[7]),
    .external_irq_pin_b(src[8]), .compare_out(co), .compare_out_oe_n(oen));
  source_partner part_u (.pclk(pclk), .presetn(presetn), .fire(fire), .idx(idx), .src(src));
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  task results;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      results();
    end
  end
  task chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h, seen %h", n, exp, seen);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask
  task pulse(input logic [3:0] i);
    @(posedge pclk);
    fire <= 1'b1;
    idx <= i;
    @(posedge pclk);
    fire <= 1'b0;
  endtask
  task t_reset;
    apb(1'b0, C2, 32'h0);
    chk("ctrl2 reset", r, 32'h0000000c);
    chk("pin enable", 32'(oen), 32'h0);
    apb(1'b1, 8'h40, 32'hffffffff);
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped", r, 32'h0);
    apb(1'b1, C2, 32'h00000f0c);
    apb(1'b0, C2, 32'h0);
    chk("ctrl2 mask", r, 32'h0000000c);
  endtask
  task t_pins;
    logic c0;
    c0 = co;
    apb(1'b1, C2, 32'h0000002c);
    chk("released", 32'(oen), 32'h1);
    apb(1'b1, C2, 32'h0000100c);
    chk("driven", 32'(oen), 32'h0);
    chk("inverted", 32'(co), 32'(!c0));
    apb(1'b1, C2, 32'h0000000c);
    chk("plain", 32'(co), 32'(c0));
  endtask
  task t_sync(input logic [4:0] code, input logic [3:0] i, input logic hit);
    apb(1'b1, C2, 32'(code));
    repeat (40) @(posedge pclk);
    pulse(i);
    repeat (8) @(posedge pclk);
    apb(1'b0, TM, 32'h0);
    chk("restart", 32'(r[15:0] < 16'h0014), 32'(hit));
  endtask
  task t_own;
    apb(1'b1, C1, 32'h0);
    apb(1'b1, SC, 32'h00000028);
    apb(1'b1, C2, 32'(compare_sync_pkg::SEL_OWN_MATCH));
    apb(1'b1, C1, 32'(compare_sync_pkg::MODE_TOGGLE));
    repeat (100) @(posedge pclk);
    apb(1'b0, TM, 32'h0);
    chk("own match", 32'(r[15:0] <= 16'h0028), 32'h1);
  endtask
  task t_trig(input logic smode, input logic [3:0] i, input logic [4:0] code);
    apb(1'b1, C1, 32'h0);
    apb(1'b1, SC, 32'h000000c8);
    // Comparator codes are only ever used with the trigger bit set
    apb(1'b1, C2, 32'h80 | 32'(code));
    apb(1'b1, C1, 32'({smode, compare_sync_pkg::MODE_TOGGLE}));
    apb(1'b0, C1, 32'h0);
    chk("ctrl1", r, 32'({smode, compare_sync_pkg::MODE_TOGGLE}));
    pulse(i);
    repeat (8) @(posedge pclk);
    apb(1'b0, C2, 32'h0);
    chk("triggered", 32'(r[6]), 32'h1);
    repeat (250) @(posedge pclk);
    apb(1'b0, C2, 32'h0);
    chk("status after match", 32'(r[6]), 32'(!smode));
    apb(1'b1, C2, 32'h80 | 32'(code));
    apb(1'b0, C2, 32'h0);
    chk("software clear", 32'(r[6]), 32'h0);
  endtask
  task t_off;
    apb(1'b1, C1, 32'h0);
    apb(1'b1, C2, 32'(compare_sync_pkg::SEL_TIMER_B));
    pulse(4'h1);
    repeat (30) @(posedge pclk);
    apb(1'b0, TM, 32'h0);
    chk("timer idle", r, 32'h0);
  endtask
  task t_modes;
    apb(1'b1, C2, 32'(compare_sync_pkg::SEL_NONE));
    apb(1'b1, compare_sync_pkg::PRIMARY_OFFSET, 32'h00000020);
    apb(1'b1, C1, 32'(compare_sync_pkg::MODE_SS_HIGH));
    chk("single shot start", 32'(co), 32'h0);
    repeat (60) @(posedge pclk);
    chk("single shot high", 32'(co), 32'h1);
    apb(1'b1, C1, 32'h0);
    apb(1'b1, C1, 32'(compare_sync_pkg::MODE_SS_LOW));
    chk("single shot init", 32'(co), 32'h1);
    repeat (60) @(posedge pclk);
    chk("single shot low", 32'(co), 32'h0);
  endtask
  initial begin
    {psel, penable, pwrite, fire, paddr, pwdata, idx, presetn} = '0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_pins();
    apb(1'b1, SC, 32'h0000ffff);
    apb(1'b1, C1, 32'(compare_sync_pkg::MODE_TOGGLE));
    t_sync(5'h1e, 4'h8, 1'b1);
    t_sync(5'h1d, 4'h7, 1'b1);
    t_sync(5'h10, 4'h4, 1'b1);
    t_sync(5'h0d, 4'h2, 1'b1);
    t_sync(5'h0c, 4'h1, 1'b1);
    t_sync(5'h0b, 4'h0, 1'b1);
    t_sync(5'h05, 4'h3, 1'b1);
    t_sync(5'h00, 4'h1, 1'b0);
    t_sync(5'h1c, 4'h8, 1'b0);
    t_own();
    t_trig(1'b1, 4'h5, 5'h18);
    t_trig(1'b0, 4'h6, 5'h19);
    t_off();
    t_modes();
    results();
  end
endmodule // testbench
`default_nettype wire
